// ---- hdl/sepi_pkg.sv ----
// Purpose: Constants and types for the serial memory pin front end.
// Assumes: Pins are sampled by clk; the serial clock is a plain input.
// Notes:   The instruction decoder and memory array sit outside this block.
//
// Overview of operation
// - Serial output is push-pull and shifts read data during reads.
// - Serial output bit changes after each serial clock falling edge.
// - Serial input sampled on each serial clock rising edge while selected.
// - Select high deselects and puts serial output in high impedance.
// - Deselected means standby, unless an internal write cycle is running.
// - Select low enables the device and puts it in active power mode.
// - After power-up, nothing happens until a select falling edge is seen.
// - Write protect low blocks nonvolatile writes; reads still work.
// - Write protect high allows all functions including writes.
// - Write protect falling during a selected write aborts that write.
// - A write cycle already started ignores later write protect changes.
// - All bytes move most significant bit first.
// - Serial clock may stop anywhere; resuming continues exactly.
package sepi_pkg;

    localparam int unsigned SEPI_BYTE_W = 8;
    localparam logic [2:0]  SEPI_BIT_RST = 3'h0;
    localparam logic [7:0]  SEPI_BYTE_RST = 8'h00;
    // Default internal write cycle length, in ns, and in clk cycles
    localparam int unsigned SEPI_CLK_NS = 4;
    localparam int unsigned SEPI_WCYC_NS = 5000000;
    localparam int unsigned SEPI_WCYC_CYC = SEPI_WCYC_NS / SEPI_CLK_NS;

    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic din;
        logic wp_n;
    } sepi_pins_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       first;
    } sepi_rx_t;

    typedef enum logic [2:0] {
        SEPI_ST_LOCK = 3'h1,
        SEPI_ST_IDLE = 3'h2,
        SEPI_ST_ACT  = 3'h4
    } sepi_state_t;

endpackage : sepi_pkg

// ---- hdl/sepi_front.sv ----
// Purpose: Pin front end of a serial memory: select, shift, tristate, power.
// Assumes: Serial clock well below clk/4; decoder supplies write requests.
// Notes:   Write cycle is timed here; its length is a parameter.
`timescale 1ns/1ps
module sepi_front
    import sepi_pkg::*;
#(
    parameter int unsigned WCYC_CYCLES = SEPI_WCYC_CYC
) (
    input  wire logic               clk,          // 250 MHz clock
    input  wire logic               rst_b,        // Async reset, power-up
    input  wire logic               sclk_pin,     // Serial clock pin
    input  wire logic               select_and_watchdog_kick_n, // Select
    input  wire logic               sdi_pin,      // Serial data input pin
    input  wire logic               wp_n_pin,     // Write protect pin
    input  wire logic [7:0]         tx_data,      // Read byte to shift out
    input  wire logic               tx_valid,     // Read byte available
    input  wire logic               wr_request,   // Decoder asks for a write
    output logic                    tx_take,      // Read byte taken, pulse
    output sepi_pkg::sepi_rx_t      rx,           // Received byte, pulse
    output logic                    sdo_out,      // Serial data out value
    output logic                    sdo_oe,       // Serial data out enable
    output logic                    active_pwr,   // Active power mode
    output logic                    wr_busy,      // Write cycle running
    output logic                    wr_start,     // Write cycle start pulse
    output logic                    wr_aborted    // Write blocked, pulse
);
    import sepi_pkg::*;

    if (WCYC_CYCLES < 1) begin : g_wcyc_chk
        $error("WCYC_CYCLES must be at least one");
    end

    localparam int unsigned CW = (WCYC_CYCLES > 1) ? $clog2(WCYC_CYCLES) : 1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sepi_pins_t  s1;
        sepi_pins_t  s2;
        sepi_pins_t  prev;
        sepi_state_t st;
        logic [2:0]  bit_cnt;
        logic [7:0]  shin;
        logic [7:0]  shout;
        logic        have_out;
        logic        first_byte;
        logic        wr_armed;
        logic        wr_killed;
        logic [CW-1:0] wcnt;
        logic        busy;
        logic        take;
        sepi_rx_t    rx;
        logic        sdo;
        logic        oe;
        logic        act;
        logic        wstart;
        logic        wabort;
    } sepi_st_t;

    sepi_st_t r_reg;
    sepi_st_t r_next;

    sepi_pins_t pins;
    assign pins = '{sclk: sclk_pin, sel_n: select_and_watchdog_kick_n,
                    din: sdi_pin, wp_n: wp_n_pin};

    // ------------------------------------------------------------
    // Edge decode, shared by the synchronised clock, select and write protect pins
    // ------------------------------------------------------------
    function automatic logic sepi_edge(input logic now_v,
                                       input logic was_v,
                                       input logic rising);
        return rising ? (now_v & ~was_v) : (~now_v & was_v);
    endfunction : sepi_edge

    logic sck_rise;
    logic sck_fall;
    logic sel_fall;
    logic sel_rise;
    logic wp_fall;
    assign sck_rise = sepi_edge(r_reg.s2.sclk, r_reg.prev.sclk, 1'b1);
    assign sck_fall = sepi_edge(r_reg.s2.sclk, r_reg.prev.sclk, 1'b0);
    assign sel_fall = sepi_edge(r_reg.s2.sel_n, r_reg.prev.sel_n, 1'b0);
    assign sel_rise = sepi_edge(r_reg.s2.sel_n, r_reg.prev.sel_n, 1'b1);
    assign wp_fall  = sepi_edge(r_reg.s2.wp_n, r_reg.prev.wp_n, 1'b0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next        = r_reg;
        r_next.s1     = pins;
        r_next.s2     = r_reg.s1;
        r_next.prev   = r_reg.s2;
        r_next.take   = 1'b0;
        r_next.rx.valid = 1'b0;
        r_next.wstart = 1'b0;
        r_next.wabort = 1'b0;

        case (r_reg.st)
            SEPI_ST_LOCK: begin
                if (sel_fall) begin
                    r_next.st = SEPI_ST_ACT;
                end
            end
            SEPI_ST_IDLE: begin
                if (sel_fall) begin
                    r_next.st = SEPI_ST_ACT;
                end
            end
            SEPI_ST_ACT: begin
                if (sel_rise) begin
                    r_next.st = SEPI_ST_IDLE;
                end
            end
            default: begin
                r_next.st = SEPI_ST_LOCK;
            end
        endcase

        if (sel_fall) begin
            r_next.bit_cnt    = SEPI_BIT_RST;
            r_next.shin       = SEPI_BYTE_RST;
            r_next.have_out   = 1'b0;
            r_next.first_byte = 1'b1;
            r_next.wr_armed   = 1'b0;
            r_next.wr_killed  = 1'b0;
        end else if (r_reg.st == SEPI_ST_ACT && !r_reg.s2.sel_n) begin
            // Edges only; a stopped clock just holds everything
            if (sck_rise) begin
                r_next.shin = {r_reg.shin[6:0], r_reg.s2.din};
                r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                if (r_reg.bit_cnt == 3'h7) begin
                    r_next.rx.valid   = 1'b1;
                    r_next.rx.data    = {r_reg.shin[6:0], r_reg.s2.din};
                    r_next.rx.first   = r_reg.first_byte;
                    r_next.first_byte = 1'b0;
                end
            end
            if (sck_fall) begin
                if (r_reg.bit_cnt == SEPI_BIT_RST) begin
                    // Load at the byte boundary; absent data drives zero
                    r_next.shout    = tx_valid ? tx_data : SEPI_BYTE_RST;
                    r_next.have_out = tx_valid;
                    r_next.take     = tx_valid;
                    r_next.sdo      = tx_valid ? tx_data[7] : 1'b0;
                end else begin
                    r_next.shout = {r_reg.shout[6:0], 1'b0};
                    r_next.sdo   = r_reg.shout[6];
                end
            end
            // A held request must not re-arm after an abort
            if (wr_request && !r_reg.wr_killed) begin
                r_next.wr_armed = 1'b1;
            end
        end

        // Write protect: only an unstarted write can be aborted
        if (r_reg.wr_armed && (wp_fall || !r_reg.s2.wp_n)) begin
            r_next.wr_armed  = 1'b0;
            r_next.wr_killed = 1'b1;
            r_next.wabort    = 1'b1;
        end else if (r_reg.wr_armed && sel_rise && r_reg.s2.wp_n
                     && !r_reg.busy) begin
            r_next.wr_armed = 1'b0;
            r_next.busy     = 1'b1;
            r_next.wstart   = 1'b1;
            r_next.wcnt     = CW'(WCYC_CYCLES - 1);
        end

        if (r_reg.busy) begin
            if (r_reg.wcnt == '0) begin
                r_next.busy = 1'b0;
            end else begin
                r_next.wcnt = r_reg.wcnt - CW'(1);
            end
        end

        // Push-pull only while selected
        r_next.oe  = (r_next.st == SEPI_ST_ACT) && !r_reg.s2.sel_n
                     && !sel_rise;
        r_next.act = r_next.oe || r_next.busy
                     || (r_next.st == SEPI_ST_ACT);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Select starts low: a pin already low at power-up gives
            // no fall, so the lock holds until a real one
            r_reg <= '{s1: '{1'b0, 1'b0, 1'b0, 1'b1},
                       s2: '{1'b0, 1'b0, 1'b0, 1'b1},
                       prev: '{1'b0, 1'b0, 1'b0, 1'b1},
                       st: SEPI_ST_LOCK, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign tx_take    = r_reg.take;
    assign rx         = r_reg.rx;
    assign sdo_out    = r_reg.sdo;
    assign sdo_oe     = r_reg.oe;
    assign active_pwr = r_reg.act;
    assign wr_busy    = r_reg.busy;
    assign wr_start   = r_reg.wstart;
    assign wr_aborted = r_reg.wabort;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_sel_high2;
        r_reg.s2.sel_n ##1 r_reg.s2.sel_n;
    endsequence

    sequence s_load_edge;
        sck_fall && !sel_fall && r_reg.st == SEPI_ST_ACT
        && !r_reg.s2.sel_n && r_reg.bit_cnt == SEPI_BIT_RST;
    endsequence

    sequence s_load_seen;
        tx_take == $past(tx_valid) ##1 !tx_take;
    endsequence

    sequence s_last_bit;
        sck_rise && !sel_fall && r_reg.st == SEPI_ST_ACT
        && !r_reg.s2.sel_n && r_reg.bit_cnt == 3'h7;
    endsequence

    a_oe_deselect: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_sel_high2 |=> !sdo_oe)
        else $error("serial output driven while deselected");
    a_standby_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_sel_high2 ##0 !r_reg.busy ##0 r_reg.st != SEPI_ST_ACT
        |=> !active_pwr)
        else $error("not in standby while idle");
    a_busy_power: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_busy |-> active_pwr)
        else $error("standby during write cycle");
    a_lock_ignore: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_reg.st == SEPI_ST_LOCK |=> !rx.valid && !tx_take)
        else $error("activity before first select fall");
    a_wp_block: assert property (
        @(posedge clk) disable iff (!rst_b)
        !r_reg.s2.wp_n |=> !wr_start)
        else $error("write started while protected");
    a_wp_abort: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_reg.wr_armed && wp_fall |=> wr_aborted ##1 !wr_start)
        else $error("protect fall did not abort write");
    a_busy_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(wr_busy) |-> wr_busy [*8])
        else $error("write cycle cut short");
    a_start_ok: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_reg.wr_armed && sel_rise && r_reg.s2.wp_n && !r_reg.busy
        |=> wr_start && wr_busy)
        else $error("allowed write did not start");
    a_sample_in: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_reg.st == SEPI_ST_ACT && !r_reg.s2.sel_n && sck_rise && !sel_fall
        |=> r_reg.shin[0] == $past(r_reg.s2.din))
        else $error("input bit not sampled on rising edge");
    a_out_fall: assert property (
        @(posedge clk) disable iff (!rst_b)
        !sck_fall |=> $stable(sdo_out))
        else $error("output changed without falling edge");

    // Frame boundaries, write abort and byte delivery
    a_lock_power: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_reg.st == SEPI_ST_LOCK |-> !active_pwr && !sdo_oe)
        else $error("powered up before first select fall");
    a_sel_active: assert property (
        @(posedge clk) disable iff (!rst_b)
        sel_fall |=> active_pwr && sdo_oe && r_reg.st == SEPI_ST_ACT)
        else $error("select fall did not enable the device");
    a_rise_drop: assert property (
        @(posedge clk) disable iff (!rst_b)
        sel_rise |=> r_reg.st != SEPI_ST_ACT && !sdo_oe)
        else $error("select rise did not end the frame");
    a_fall_restart: assert property (
        @(posedge clk) disable iff (!rst_b)
        sel_fall |=> r_reg.bit_cnt == SEPI_BIT_RST && r_reg.first_byte)
        else $error("bit counter not restarted on select fall");
    a_abort_final: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_aborted |=> !r_reg.wr_armed && !wr_start)
        else $error("aborted write armed again");
    a_load_take: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_load_edge |=> s_load_seen)
        else $error("read byte not loaded at byte boundary");
    a_last_bit: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_last_bit |=> rx.valid && rx.data[0] == $past(r_reg.s2.din))
        else $error("byte not delivered after eighth bit");

endmodule : sepi_front

// ---- verification/sepi_master_model.sv ----
// Purpose: Serial bus master model driving the front end pins.
// Assumes: Clock idles high; 12 clk per bit gives a 48 ns serial clock.
// Notes:   Clock stands still between frames.
`timescale 1ns/1ps
module sepi_master_model (
    input  wire logic clk,          // Bench clock
    input  wire logic sdo,          // Resolved serial out line
    output logic      sclk = 1'b1,  // Serial clock pin
    output logic      sel_n = 1'b1, // Select pin, active low
    output logic      sdi = 1'b0    // Serial data to device
);
    // --------------------------------------------
    // One frame; sel_lvl high models a stray burst
    // --------------------------------------------
    task automatic frame(input logic [7:0] d, input int nbits,
                         input int stall, input logic sel_lvl,
                         output logic [7:0] q);
        q = 8'h00;
        @(posedge clk);
        sel_n <= sel_lvl;
        repeat (8) @(posedge clk);
        for (int i = 7; i > 7 - nbits; i--) begin
            sclk <= 1'b0;
            sdi  <= d[i];
            repeat (5) @(posedge clk);
            @(negedge clk) q[i] = sdo;
            @(posedge clk);
            sclk <= 1'b1;
            repeat (6) @(posedge clk);
            if (i == 4) repeat (stall) @(posedge clk);
        end
        sel_n <= 1'b1;
        // Released line must not keep the last bit
        sdi   <= ~sdi;
        repeat (12) @(posedge clk);
    endtask : frame

    // Moves select alone, with no serial clocking
    task automatic hold_sel(input logic lvl);
        @(posedge clk);
        sel_n <= lvl;
    endtask : hold_sel
endmodule : sepi_master_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the serial memory pin front end.
// Assumes: Write cycle shortened to 20 clk.
// Notes:   Output pulses are counted each clk; tasks compare deltas.
`timescale 1ns/1ps
module tb_top;
    import sepi_pkg::*;
    localparam int unsigned WCYC = 20;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       wp_n = 1'b1;
    logic [7:0] tx_data = 8'h96;
    logic       tx_valid = 1'b1;
    logic       wr_req = 1'b0;
    logic       sclk, sel_n, sdi, tx_take, sdo_out, sdo_oe;
    logic       act, busy, wr_start, wr_abort;
    sepi_rx_t   rx, rx_seen;
    int         num_errors = 0;
    int         n_checks = 0;
    int         n_rx = 0, n_st = 0, n_ab = 0, n_bz = 0, n_tk = 0;
    // Undriven line shows the inverse, never a stale bit
    wire        sdo_line = sdo_oe ? sdo_out : ~sdo_out;

    always #2 clk = ~clk;
    always @(posedge clk) begin
        n_rx <= n_rx + (rx.valid === 1'b1);
        n_st <= n_st + (wr_start === 1'b1);
        n_ab <= n_ab + (wr_abort === 1'b1);
        n_bz <= n_bz + (busy === 1'b1);
        n_tk <= n_tk + (tx_take === 1'b1);
        if (rx.valid === 1'b1) rx_seen <= rx;
    end

    sepi_front #(.WCYC_CYCLES(WCYC)) dut_u (
        .clk(clk), .rst_b(rst_b), .sclk_pin(sclk),
        .select_and_watchdog_kick_n(sel_n), .sdi_pin(sdi),
        .wp_n_pin(wp_n), .tx_data(tx_data), .tx_valid(tx_valid),
        .wr_request(wr_req), .tx_take(tx_take), .rx(rx),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .active_pwr(act),
        .wr_busy(busy), .wr_start(wr_start), .wr_aborted(wr_abort));
    sepi_master_model mst_u (.clk(clk), .sdo(sdo_line), .sclk(sclk),
        .sel_n(sel_n), .sdi(sdi));

    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic t_lock();
        logic [7:0] q;
        mst_u.frame(8'hff, 8, 0, 1'b1, q);
        check("lock_rx", 0, n_rx);
        check("lock_oe", 0, sdo_oe);
        check("lock_pwr", 0, act);
        // Select already low at power-up is not a falling edge
        mst_u.hold_sel(1'b0);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        mst_u.frame(8'h5a, 8, 0, 1'b0, q);
        check("lock_low_rx", 0, n_rx);
        check("lock_low_take", 0, n_tk);
        check("lock_low_pwr", 0, act);
    endtask : t_lock

    task automatic t_read();
        logic [7:0] q;
        int         t0 = n_tk;
        fork
            mst_u.frame(8'h00, 8, 0, 1'b0, q);
            begin
                repeat (20) @(negedge clk);
                check("rd_oe", 1, sdo_oe);
                check("rd_pwr", 1, act);
            end
        join
        check("rd_byte", 8'h96, q);
        check("rd_take", t0 + 1, n_tk);
    endtask : t_read

    task automatic t_write(input logic wp_lvl, input int fall_at,
                           input logic late, input logic [7:0] d);
        logic [7:0] q;
        logic       ok = wp_lvl && fall_at == 0;
        int         s0 = n_st;
        int         a0 = n_ab;
        int         b0 = n_bz;
        int         r0 = n_rx;
        wp_n   <= wp_lvl;
        wr_req <= 1'b1;
        fork
            mst_u.frame(d, 8, 0, 1'b0, q);
            if (fall_at > 0) begin
                repeat (fall_at) @(posedge clk);
                wp_n <= 1'b0;
            end
        join
        wr_req <= 1'b0;
        if (late) wp_n <= 1'b0;
        @(negedge clk);
        check("wr_pwr", ok, act);
        check("wr_oe", 0, sdo_oe);
        for (int k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
        check("wr_done", 0, busy);
        if (busy !== 1'b0) stop_test();
        @(negedge clk);
        check("wr_start", s0 + ok, n_st);
        check("wr_abort", a0 + !ok, n_ab);
        check("wr_cycles", ok ? WCYC : 0, n_bz - b0);
        check("wr_idle", 0, act);
        check("wr_rx", r0 + 1, n_rx);
        check("wr_byte", d, rx_seen.data);
    endtask : t_write

    task automatic t_partial();
        logic [7:0] q;
        int         r0 = n_rx;
        int         t0 = n_tk;
        // No read byte on offer: zeros go out and nothing is taken
        tx_valid <= 1'b0;
        mst_u.frame(8'hff, 3, 0, 1'b0, q);
        mst_u.frame(8'h5a, 8, 50, 1'b0, q);
        tx_valid <= 1'b1;
        check("part_cnt", r0 + 1, n_rx);
        check("part_byte", 8'h5a, rx_seen.data);
        check("part_first", 1, rx_seen.first);
        check("part_sdo", 8'h00, q);
        check("part_take", t0, n_tk);
    endtask : t_partial

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_lock();
        t_read();
        t_write(1'b1, 0, 1'b0, 8'ha5);
        t_write(1'b0, 0, 1'b0, 8'h3c);
        t_write(1'b1, 60, 1'b0, 8'hc3);
        t_write(1'b1, 0, 1'b1, 8'h81);
        t_partial();
        stop_test();
    end
endmodule : tb_top
